// [hdsl_seq_regs.svh]
/*
 Constants of the start-up sequencer: timings in symbol intervals unless
 the name says ns, loss thresholds in dB and the scrambler seed.
 Assumes a 100 MHz system clock.
*/
`ifndef HDSL_SEQ_REGS_SVH
`define HDSL_SEQ_REGS_SVH
// ============================================
// Clock and symbol period
`define CLK_NS 16'h000A
`define SYMBOL_NS 16'h10B9
// ============================================
// Start-up timers, in symbols
`define T1_SYM 21'h0BB8
`define T2_SYM 21'h2134
`define T3_SYM 21'h1388
`define T4_SYM 21'h00FA
`define T5_SYM 21'h05DC
`define T8_SYM 21'h6B6C
`define CS0_SYM 21'h0100
`define RS0_SYM 21'h0100
// ============================================
// Sequence lengths
`define CS1_TRAIN_SYM 21'h10_C8E0
`define RS1_TRAIN_SYM 21'h0CE4
`define STAMP_SYM 21'h0122
`define GAP_SYM 21'h000D
`define IDEAL_SYM 21'h8_ED28
`define RS1_EC_SYM 21'h1_F400
// ============================================
// Power selection and scrambler seed
`define LOSS_HP_DB 8'h09
`define LOSS_LP_DB 8'h06
`define SCR_SEED 24'h00_0000
`endif

// [hdsl_seq_pkg.sv]
/*
 Types shared by the start-up sequencer and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hdsl_seq_pkg;
   // Line sequence being sent
   typedef enum logic [2:0] {
      SEQ_SILENT = 3'b000,
      SEQ_S0 = 3'b001,
      SEQ_S1 = 3'b010,
      SEQ_STAMP = 3'b011,
      SEQ_IDEAL = 3'b100
   } tx_seq_t;

   // Sequencer states of both line ends
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00000,
      ST_POLL = 5'b00001,
      ST_LISTEN = 5'b00010,
      ST_WAIT_T2 = 5'b00011,
      ST_WAIT_T4 = 5'b00100,
      ST_TRAIN = 5'b00101,
      ST_STAMP = 5'b00110,
      ST_GAP = 5'b00111,
      ST_IDEAL = 5'b01000,
      ST_QUIET = 5'b01001,
      ST_REPLY = 5'b01010,
      ST_WAIT_T3 = 5'b01011,
      ST_WAIT_T5 = 5'b01100,
      ST_RS1 = 5'b01101,
      ST_RECOVER = 5'b01110,
      ST_EC = 5'b01111,
      ST_DONE = 5'b10000
   } state_t;

   // Receiver detections, one-cycle pulses
   typedef struct packed {
      logic cs0;
      logic rs0;
      logic cs1;
      logic ideal_end;
   } rx_ev_t;

   // Transmit control toward the modulator
   typedef struct packed {
      tx_seq_t seq;
      logic chan_b;
      logic scr_reset;
      logic scr_ones;
      logic agc_train;
      logic ec_train;
      logic eq_train;
      logic activated;
   } tx_t;
endpackage

// [hdsl_startup_sequencer.sv]
/*
 Start-up sequencer for one end of a CAP line link: alerting, power
 mode choice, front-end training, time stamp, ideal reference and
 echo canceller phases. Assumes receiver detectors deliver one-cycle
 pulses synchronous to clock, and a modulator that obeys tx.
*/
`include "hdsl_seq_regs.svh"
module hdsl_startup_sequencer
#(
   parameter bit IS_NTU = 1'b0,
   parameter logic [20:0] T1_SYM = `T1_SYM,
   parameter logic [20:0] T2_SYM = `T2_SYM,
   parameter logic [20:0] T3_SYM = `T3_SYM,
   parameter logic [20:0] T4_SYM = `T4_SYM,
   parameter logic [20:0] T5_SYM = `T5_SYM,
   parameter logic [20:0] T8_SYM = `T8_SYM,
   parameter logic [20:0] CS0_SYM = `CS0_SYM,
   parameter logic [20:0] RS0_SYM = `RS0_SYM,
   parameter logic [20:0] CS1_SYM = `CS1_TRAIN_SYM,
   parameter logic [20:0] RS1_SYM = `RS1_TRAIN_SYM,
   parameter logic [20:0] IDEAL_SYM = `IDEAL_SYM,
   parameter logic [20:0] EC_SYM = `RS1_EC_SYM,
   parameter logic [15:0] SYM_CYCLES = `SYMBOL_NS / `CLK_NS
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic act_req,
   input wire logic two_pair,
   input wire logic single_mode,
   input wire logic chan_b_sel,
   input wire hdsl_seq_pkg::rx_ev_t rx,
   input wire logic rx_level_valid,
   input wire logic [7:0] rx_loss_db,
   input wire logic prefer_high,
   output hdsl_seq_pkg::tx_t tx,
   output logic power_high,
   output logic [23:0] scr_seed,
   output logic sym_tick
);
   import hdsl_seq_pkg::*;

   // ============================================
   // Symbol timing
   logic [15:0] div_reg;
   logic tick_reg;
   wire div_wrap = (div_reg == SYM_CYCLES - 16'h0001);

   // Free running, never realigned, so the NTU holds timing while the
   // far end is quiet; only sys_rst restarts it
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         div_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_wrap ? 16'h0000 : div_reg + 16'h0001;
         tick_reg <= div_wrap;
      end
   end
   assign sym_tick = tick_reg;

   // ============================================
   // Per-state duration, in symbols; zero means no timeout
   function automatic logic [20:0] dur_of(input state_t s);
      case (s)
         ST_POLL: dur_of = CS0_SYM;
         ST_LISTEN: dur_of = T1_SYM;
         ST_WAIT_T2: dur_of = T2_SYM;
         ST_WAIT_T4: dur_of = T4_SYM;
         ST_TRAIN: dur_of = CS1_SYM;
         ST_STAMP: dur_of = `STAMP_SYM;
         ST_GAP: dur_of = `GAP_SYM;
         ST_IDEAL: dur_of = IDEAL_SYM;
         ST_QUIET: dur_of = T8_SYM;
         ST_REPLY: dur_of = RS0_SYM;
         ST_WAIT_T3: dur_of = T3_SYM;
         ST_WAIT_T5: dur_of = T5_SYM;
         ST_RS1: dur_of = RS1_SYM;
         ST_EC: dur_of = EC_SYM;
         default: dur_of = 21'h0_0000;
      endcase
   endfunction

   // States in which the link counts as activated
   function automatic logic active_of(input state_t s);
      active_of = (s == ST_TRAIN) || (s == ST_STAMP) ||
         (s == ST_GAP) || (s == ST_IDEAL) || (s == ST_QUIET) ||
         (s == ST_RS1) || (s == ST_RECOVER) || (s == ST_EC) ||
         (s == ST_DONE);
   endfunction

   state_t state_reg;
   state_t state_next;
   logic [20:0] cnt_reg;
   logic second_reg;
   logic chan_reg;
   logic lock_reg;
   logic power_reg;
   tx_t tx_reg;
   tx_t tx_next;

   // ============================================
   // Timer decode
   wire [20:0] dur = dur_of(state_reg);
   wire expire = tick_reg && (dur != 21'h0_0000) &&
      (cnt_reg == dur - 21'h0_0001);
   wire alerting = !active_of(state_reg);

   // Next state; dropping act_req returns to idle from anywhere
   always_comb
   begin
      state_next = state_reg;
      if (!act_req)
         state_next = ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
               if (!IS_NTU)
                  state_next = ST_POLL;
               else if (rx.cs0)
                  state_next = ST_REPLY;
            ST_POLL:
               if (expire)
                  state_next = ST_LISTEN;
            ST_LISTEN:
               if (rx.rs0)
                  state_next = two_pair ? ST_WAIT_T2 : ST_WAIT_T4;
               else if (expire)
                  state_next = ST_POLL;
            ST_WAIT_T2:
               if (rx.rs0 && single_mode)
                  state_next = ST_WAIT_T4;
               else if (expire)
                  state_next = ST_POLL;
            ST_WAIT_T4:
               if (expire)
                  state_next = ST_TRAIN;
            ST_TRAIN:
               if (expire)
                  state_next = ST_STAMP;
            ST_STAMP:
               if (expire)
                  state_next = ST_GAP;
            ST_GAP:
               if (expire)
                  state_next = ST_IDEAL;
            ST_IDEAL:
               if (expire)
                  state_next = IS_NTU ? ST_DONE : ST_QUIET;
            ST_QUIET:
               if (expire)
                  state_next = ST_DONE;
            ST_REPLY:
               if (expire)
                  state_next = (two_pair && !second_reg) ?
                     ST_WAIT_T3 : ST_WAIT_T5;
            ST_WAIT_T3:
               if (rx.cs0)
                  state_next = ST_WAIT_T5;
               else if (expire)
                  state_next = ST_REPLY;
            ST_WAIT_T5:
               if (rx.cs1)
                  state_next = ST_RS1;
               else if (expire)
                  state_next = ST_IDLE;
            ST_RS1:
               if (expire)
                  state_next = ST_RECOVER;
            ST_RECOVER:
               if (rx.ideal_end)
                  state_next = ST_EC;
            ST_EC:
               if (expire)
                  state_next = ST_STAMP;
            ST_DONE:
               state_next = ST_DONE;
            default:
               state_next = ST_IDLE;
         endcase
      end
   end

   // Transmit control follows the state being entered
   always_comb
   begin
      tx_next = '0;
      unique case (state_next)
         ST_POLL, ST_REPLY: tx_next.seq = SEQ_S0;
         ST_TRAIN, ST_GAP, ST_RS1, ST_EC, ST_DONE:
            tx_next.seq = SEQ_S1;
         ST_STAMP: tx_next.seq = SEQ_STAMP;
         ST_IDEAL: tx_next.seq = SEQ_IDEAL;
         default: tx_next.seq = SEQ_SILENT;
      endcase
      // Taken straight from the select on leaving idle, so the first CS0
      // burst already goes out on the chosen channel
      tx_next.chan_b = (state_reg == ST_IDLE) ? chan_b_sel :
         chan_reg;
      tx_next.scr_reset = (state_next == ST_IDEAL) &&
         (state_reg != ST_IDEAL);
      tx_next.scr_ones = (state_next == ST_IDEAL);
      tx_next.agc_train = (state_next == ST_TRAIN) ||
         (state_next == ST_RS1);
      tx_next.ec_train = (state_next == ST_EC) ||
         (!IS_NTU && state_next == ST_TRAIN);
      tx_next.eq_train = (state_next == ST_RECOVER) ||
         (!IS_NTU && state_next == ST_DONE);
      tx_next.activated = active_of(state_next);
   end

   // Power choice is taken once, from the first level seen while alerting
   wire take_level = alerting && rx_level_valid && !lock_reg;
   wire pick_high = (rx_loss_db > `LOSS_HP_DB) ? 1'b1 :
      (rx_loss_db < `LOSS_LP_DB) ? 1'b0 : prefer_high;

   // ============================================
   // State, timer and output registers
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 21'h0_0000;
         second_reg <= 1'b0;
         chan_reg <= 1'b0;
         lock_reg <= 1'b0;
         power_reg <= 1'b0;
         tx_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_next != state_reg)
            cnt_reg <= 21'h0_0000;
         else if (tick_reg)
            cnt_reg <= cnt_reg + 21'h0_0001;
         if (state_next == ST_IDLE)
            second_reg <= 1'b0;
         else if (state_reg == ST_WAIT_T3 && state_next == ST_REPLY)
            second_reg <= 1'b1;
         if (state_reg == ST_IDLE)
            chan_reg <= chan_b_sel;
         if (take_level)
         begin
            lock_reg <= 1'b1;
            power_reg <= pick_high;
         end
         tx_reg <= tx_next;
      end
   end

   assign tx = tx_reg;
   assign power_high = power_reg;
   assign scr_seed = `SCR_SEED;

   // ============================================
   // Checks
   idle_silent_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_IDLE |-> tx_reg.seq == SEQ_SILENT)
      else $error("idle state not silent");
   poll_sends_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_POLL |-> tx_reg.seq == SEQ_S0 &&
      tx_reg.chan_b == chan_reg)
      else $error("poll not sending S0 on chosen channel");
   chan_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg != ST_IDLE |=> $stable(chan_reg))
      else $error("channel changed during activation");
   t2_start_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_LISTEN && rx.rs0 && two_pair && act_req
      |=> state_reg == ST_WAIT_T2 && cnt_reg == 21'h0_0000)
      else $error("T2 not started on first reply");
   // Retry only once the full T2 span has passed without a second reply
   t2_retry_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_WAIT_T2 && state_next == ST_POLL && act_req
      |-> cnt_reg == T2_SYM - 21'h0_0001 && tick_reg)
      else $error("T2 retry at wrong time");
   t4_delay_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_WAIT_T4 ##1 state_reg == ST_TRAIN
      |-> $past(cnt_reg) == T4_SYM - 21'h0_0001 &&
      tx_reg.seq == SEQ_S1)
      else $error("CS1 not started after T4");
   t3_again_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_WAIT_T3 && expire && act_req && !rx.cs0
      |=> state_reg == ST_REPLY && tx_reg.seq == SEQ_S0)
      else $error("RS0 not repeated after T3");
   stamp_len_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_STAMP && state_next == ST_GAP
      |-> cnt_reg == `STAMP_SYM - 21'h0_0001)
      else $error("time stamp length wrong");
   gap_len_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_GAP && state_next == ST_IDEAL
      |-> cnt_reg == `GAP_SYM - 21'h0_0001 ##1 tx_reg.scr_reset
      ##1 !tx_reg.scr_reset && tx_reg.scr_ones)
      else $error("scrambler reset misplaced");
   ideal_len_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_IDEAL && state_next != ST_IDEAL && act_req
      |-> cnt_reg == IDEAL_SYM - 21'h0_0001)
      else $error("ideal reference length wrong");
   quiet_len_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_QUIET && state_next == ST_DONE
      |-> cnt_reg == T8_SYM - 21'h0_0001 ##1 tx_reg.seq == SEQ_S1)
      else $error("quiet interval wrong");
   rs1_reply_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_reg == ST_WAIT_T5 && rx.cs1 && act_req
      |=> tx_reg.seq == SEQ_S1 && tx_reg.activated)
      else $error("RS1 not started on CS1");
   power_pick_a: assert property (@(posedge clock) disable iff (sys_rst)
      take_level && rx_loss_db > `LOSS_HP_DB |=> power_high)
      else $error("high power not chosen");
   power_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      lock_reg |=> $stable(power_high))
      else $error("power mode changed");
endmodule

// [far_end_model.sv]
/*
 Behavioural model of the transceiver at the other end of the line.
 With FAR_NTU set it answers as the network end, otherwise as the line
 end. Assumes the sequencer's tx.seq is watched and rx pulses are fed
 back to that sequencer.
*/
module far_end_model
#(
   parameter bit FAR_NTU = 1'b1
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire hdsl_seq_pkg::tx_seq_t seq,
   input wire logic start,
   input wire logic [1:0] replies,
   output hdsl_seq_pkg::rx_ev_t rx
);
   import hdsl_seq_pkg::*;
   tx_seq_t last_reg;
   logic [3:0] dly_reg;
   logic [1:0] sent_reg;
   logic [1:0] ev_reg;

   // ==================================================
   // Reply scheduler
   // Replies come a few cycles after the near end stops sending, as a
   // real detector needs the burst end before it can answer
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx <= '0;
         last_reg <= SEQ_SILENT;
         dly_reg <= '0;
         sent_reg <= '0;
         ev_reg <= '0;
      end
      else
      begin
         rx <= '0;
         last_reg <= seq;
         if (start)
            rx.cs0 <= 1'b1; // Far line end alerts
         if (dly_reg > 4'h1)
            dly_reg <= dly_reg - 4'h1;
         else if (dly_reg == 4'h1)
         begin
            dly_reg <= '0;
            case (ev_reg)
               2'h1:
               begin
                  rx.rs0 <= 1'b1; // Alerted reply
                  sent_reg <= sent_reg + 2'h1;
                  if (sent_reg + 2'h1 < replies)
                     dly_reg <= 4'hA; // Second reply inside T2
               end
               2'h2: rx.cs1 <= 1'b1; // CS1 after RS0
               default: rx.ideal_end <= 1'b1; // Reference done
            endcase
         end
         else if (last_reg == SEQ_S0 && seq == SEQ_SILENT &&
            sent_reg < replies)
         begin
            dly_reg <= 4'h2;
            ev_reg <= FAR_NTU ? 2'h1 : 2'h2;
         end
         else if (!FAR_NTU && last_reg == SEQ_S1 && seq == SEQ_SILENT)
         begin
            dly_reg <= 4'h2;
            ev_reg <= 2'h3;
         end
      end
   end
endmodule

// [hdsl_startup_sequencer_test.sv]
/*
 Self-checking bench: a line end and a network end sequencer, each
 facing a model of its far end. Assumes shortened timers and four
 clocks per symbol.
*/
module hdsl_startup_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import hdsl_seq_pkg::*;
   localparam int SYM = 4;
   localparam logic [15:0] SYMC = 16'h0004;
   localparam logic [20:0] T1 = 21'h0_0005, T2 = 21'h0_000C;
   localparam logic [20:0] T3 = 21'h0_0006, T4 = 21'h0_0003;
   localparam logic [20:0] T5 = 21'h0_0014, T8 = 21'h0_0005;
   localparam logic [20:0] SH = 21'h0_0004, ID = 21'h0_0006;
   logic clock, sys_rst, act_req, two_pair, single_mode, chan_b_sel;
   logic rx_level_valid, prefer_high, start_cs0, ntu_sel;
   logic [7:0] rx_loss_db;
   logic [1:0] replies;
   rx_ev_t rx_l, rx_n;
   tx_t tx_l, tx_n, txv;
   logic power_l, power_n, tick_l, tick_n;
   logic [23:0] seed_l, seed_n;
   int errors = 0;
   int comparisons = 0;
   assign txv = ntu_sel ? tx_n : tx_l;

   // ==================================================
   // Both ends share stimulus; they differ in IS_NTU and in their far-end models
   hdsl_startup_sequencer #(.IS_NTU(1'b0), .T1_SYM(T1), .T2_SYM(T2),
      .T3_SYM(T3), .T4_SYM(T4), .T5_SYM(T5), .T8_SYM(T8), .CS0_SYM(SH),
      .RS0_SYM(SH), .CS1_SYM(SH), .RS1_SYM(SH), .IDEAL_SYM(ID),
      .EC_SYM(SH), .SYM_CYCLES(SYMC)) hdsl_startup_sequencer_i (
      .clock(clock), .sys_rst(sys_rst), .act_req(act_req),
      .two_pair(two_pair), .single_mode(single_mode),
      .chan_b_sel(chan_b_sel), .rx(rx_l), .rx_level_valid(rx_level_valid),
      .rx_loss_db(rx_loss_db), .prefer_high(prefer_high), .tx(tx_l),
      .power_high(power_l), .scr_seed(seed_l), .sym_tick(tick_l));
   hdsl_startup_sequencer #(.IS_NTU(1'b1), .T1_SYM(T1), .T2_SYM(T2),
      .T3_SYM(T3), .T4_SYM(T4), .T5_SYM(T5), .T8_SYM(T8), .CS0_SYM(SH),
      .RS0_SYM(SH), .CS1_SYM(SH), .RS1_SYM(SH), .IDEAL_SYM(ID),
      .EC_SYM(SH), .SYM_CYCLES(SYMC)) hdsl_startup_sequencer_ntu_i (
      .clock(clock), .sys_rst(sys_rst), .act_req(act_req),
      .two_pair(two_pair), .single_mode(single_mode),
      .chan_b_sel(chan_b_sel), .rx(rx_n), .rx_level_valid(rx_level_valid),
      .rx_loss_db(rx_loss_db), .prefer_high(prefer_high), .tx(tx_n),
      .power_high(power_n), .scr_seed(seed_n), .sym_tick(tick_n));
   far_end_model #(.FAR_NTU(1'b1)) far_end_model_i (.clock(clock),
      .sys_rst(sys_rst), .seq(tx_l.seq), .start(1'b0),
      .replies(replies), .rx(rx_l));
   far_end_model #(.FAR_NTU(1'b0)) far_end_model_ltu_i (.clock(clock),
      .sys_rst(sys_rst), .seq(tx_n.seq), .start(start_cs0),
      .replies(replies), .rx(rx_n));

   // ==================================================
   // Clock and shared helpers
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Cycle counts are bench integers, compared against a window
   task automatic check_in(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic do_reset(input logic ntu);
      @(negedge clock);
      sys_rst = 1'b1;
      act_req = 1'b0;
      start_cs0 = 1'b0;
      ntu_sel = ntu;
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
   endtask

   task automatic wait_seq(input tx_seq_t s, output int n);
      n = 0;
      while (txv.seq !== s && n < 3000)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 3000)
         check(txv.seq, s);
   endtask

   // Measures how many cycles the given sequence is sent, against a length in symbols
   task automatic hold(input tx_seq_t s, input int len);
      int n;
      wait_seq(s, n);
      n = 0;
      while (txv.seq === s && n < 3000)
      begin
         @(negedge clock);
         n++;
      end
      check_in(n, SYM * (len - 1) + 1, SYM * len);
   endtask

   task automatic wait_rs0(input int k);
      int c, n;
      c = 0;
      n = 0;
      while (c < k && n < 3000)
      begin
         @(negedge clock);
         n++;
         if (rx_l.rs0 === 1'b1)
            c++;
      end
      check(c, k);
   endtask

   task automatic go(input logic tp, input logic [1:0] r);
      two_pair = tp;
      single_mode = 1'b1;
      replies = r;
      act_req = 1'b1;
   endtask

   // ==================================================
   // Scenarios
   task automatic t_reset();
      int n;
      do_reset(1'b0);
      check(txv.seq, SEQ_SILENT);
      check({power_l, power_n, tx_l.activated}, 3'h0);
      check(seed_l, 24'h00_0000);
      wait_seq(SEQ_SILENT, n);
      n = 0;
      while (tick_l !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n++;
      end
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (tick_l !== 1'b1 && n < 20);
      check_in(n, SYM, SYM);
      check({tick_l, tick_n}, 2'h3);
   endtask

   task automatic t_poll();
      for (int c = 0; c < 2; c++)
      begin
         do_reset(1'b0);
         chan_b_sel = c[0];
         go(1'b1, 2'h0);
         @(negedge clock);
         check(tx_l.chan_b, c[0]);
         hold(SEQ_S0, SH);
         hold(SEQ_SILENT, T1);
         hold(SEQ_S0, SH);
      end
   endtask

   task automatic t_alert(input logic [1:0] r);
      int n;
      do_reset(1'b0);
      chan_b_sel = 1'b0;
      go(1'b1, r);
      wait_rs0(r);
      if (r == 2'h2)
      begin
         wait_seq(SEQ_S1, n);
         check_in(n, SYM * (T4 - 1) + 2, SYM * T4 + 2);
      end
      else
      begin
         wait_seq(SEQ_S0, n);
         check_in(n, SYM * (T2 - 1) + 2, SYM * T2 + 2);
      end
   endtask

   task automatic t_ltu_full();
      int n;
      do_reset(1'b0);
      go(1'b0, 2'h1);
      wait_rs0(1);
      wait_seq(SEQ_S1, n);
      check_in(n, 2, SYM * T4 + 2);
      check({tx_l.agc_train, tx_l.ec_train}, 2'h3);
      hold(SEQ_S1, SH);
      hold(SEQ_STAMP, 290);
      hold(SEQ_S1, 13);
      check({tx_l.scr_reset, tx_l.scr_ones}, 2'h3);
      check(seed_l, 24'h00_0000);
      hold(SEQ_IDEAL, ID);
      hold(SEQ_SILENT, T8);
      check(txv.seq, SEQ_S1);
   endtask

   task automatic t_ntu_full();
      int n;
      do_reset(1'b1);
      go(1'b0, 2'h1);
      start_cs0 = 1'b1;
      @(negedge clock);
      start_cs0 = 1'b0;
      hold(SEQ_S0, SH);
      check(tx_n.activated, 1'b0);
      wait_seq(SEQ_S1, n);
      check_in(n, 1, 4);
      check({tx_n.activated, tx_n.agc_train}, 2'h3);
      hold(SEQ_S1, SH);
      check(tx_n.eq_train, 1'b1);
      wait_seq(SEQ_S1, n);
      check(tx_n.ec_train, 1'b1);
      hold(SEQ_S1, SH);
      hold(SEQ_STAMP, 290);
      hold(SEQ_S1, 13);
      check(tx_n.scr_reset, 1'b1);
      check(seed_n, 24'h00_0000);
      hold(SEQ_IDEAL, ID);
   endtask

   task automatic t_ntu_fallback();
      do_reset(1'b1);
      go(1'b1, 2'h0);
      start_cs0 = 1'b1;
      @(negedge clock);
      start_cs0 = 1'b0;
      hold(SEQ_S0, SH);
      hold(SEQ_SILENT, T3);
      check(txv.seq, SEQ_S0);
   endtask

   task automatic t_power();
      logic [7:0] loss [6] = '{8'h05, 8'h0A, 8'h06, 8'h09, 8'h07, 8'h07};
      logic pref [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      logic exp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++)
      begin
         do_reset(1'b0);
         for (int k = 0; k < 2; k++)
         begin
            rx_loss_db = (k == 0) ? loss[i] : (exp[i] ? 8'h02 : 8'h0C);
            prefer_high = (k == 0) ? pref[i] : ~pref[i];
            rx_level_valid = 1'b1;
            @(negedge clock);
            rx_level_valid = 1'b0;
            repeat (2) @(negedge clock);
            check({power_l, power_n}, {2{exp[i]}});
         end
      end
   endtask

   // ==================================================
   // Main sequence and watchdog
   initial
   begin
      sys_rst = 1'b1;
      act_req = 1'b0;
      two_pair = 1'b0;
      single_mode = 1'b0;
      chan_b_sel = 1'b0;
      rx_level_valid = 1'b0;
      prefer_high = 1'b0;
      start_cs0 = 1'b0;
      ntu_sel = 1'b0;
      rx_loss_db = 8'h00;
      replies = 2'h0;
      t_reset();
      t_poll();
      t_alert(2'h2);
      t_alert(2'h1);
      t_ltu_full();
      t_ntu_full();
      t_ntu_fallback();
      t_power();
      close_out();
   end

   // Whole run is about 3 000 cycles; stop at 20 000 to catch a hang
   initial
   begin
      #200000;
      errors++;
      close_out();
   end
endmodule
